// *** pmx_pkg.sv ***
// Package for the pad mux and pulse-width configuration block.
// Assumes a single 40 MHz clock and a simple strobe register port.
package pmx_pkg;
  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] PMX_PWM_OUTPUT_CONTROL_OFS = 8'h28;
  localparam logic [7:0] PMX_ROUTE_OFS = 8'h2C;
  localparam logic [7:0] PMX_ADSEL_OFS = 8'h30;
  localparam logic [7:0] PMX_PULL_OFS = 8'h38;
  localparam logic [7:0] PMX_HYST_OFS = 8'h3C;
  localparam logic [7:0] PMX_DRV_OFS = 8'h40;
  localparam logic [7:0] PMX_STAT_OFS = 8'h4C;
  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int PMX_POL_BIT = 27;
  localparam int PMX_MODE_BIT = 26;
  localparam int PMX_RAMP_LSB = 24;
  localparam int PMX_HIGH_LSB = 16;
  localparam int PMX_LOW_LSB = 8;
  localparam int PMX_SIN_BIT = 21;
  localparam int PMX_P14_BIT = 19;
  localparam int PMX_P13_BIT = 18;
  localparam int PMX_P12_BIT = 17;
  localparam int PMX_DRV_PADS = 10;
  localparam int PMX_DRV_W = 3;
  // ********************************************************
  // Write masks and reset values
  // ********************************************************
  localparam logic [31:0] PMX_PWM_MASK = 32'h0FFF_FFFF;
  localparam logic [31:0] PMX_ROUTE_MASK = 32'h002E_FFFF;
  localparam logic [31:0] PMX_ADSEL_MASK = 32'h0000_00FF;
  localparam logic [31:0] PMX_PULL_MASK = 32'h0000_00FF;
  localparam logic [31:0] PMX_HYST_MASK = 32'h0007_FFFF;
  localparam logic [31:0] PMX_DRV_MASK = 32'h3FFF_FFFF;
  localparam logic [31:0] PMX_DRV_RST = 32'h0924_9259;
  localparam logic [31:0] PMX_ZERO_RST = 32'h0000_0000;
  // ********************************************************
  // Timing
  // ********************************************************
  localparam int PMX_TICK_UNIT = 32;
  localparam int PMX_RAMP_STEPS = 32;
  localparam int PMX_NORM_PERIOD = 256;
  // Breathing phases
  typedef enum logic [1:0] {
    PMX_RISE = 2'b00,
    PMX_HOLD_HI = 2'b01,
    PMX_FALL = 2'b10,
    PMX_HOLD_LO = 2'b11
  } pmx_phase_type;
endpackage

// *** pmx_breath.sv ***
// Breathing waveform generator for the pulse-width output.
// Assumes src_tick_i is a one-cycle pulse per source-clock period.
`timescale 1ns/10ps
`default_nettype none
module pmx_breath (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic run_i, // Breathing mode enabled
  input wire logic src_tick_i, // Source clock period tick
  input wire logic [1:0] ramp_i, // Ramp field
  input wire logic [7:0] high_i, // Full-duty hold field
  input wire logic [7:0] low_i, // Zero-duty hold field
  output logic wave_o, // Breathing output
  output pmx_pkg::pmx_phase_type phase_o // Current phase
);
  import pmx_pkg::*;
  logic [4:0] sub_reg; // 32-period sub slot counter
  logic [4:0] level_reg; // Duty level of the ramp
  logic [6:0] rep_reg; // Repeats of each level within a ramp step
  logic [7:0] hold_reg; // Hold length counter in 32t units
  pmx_phase_type phase_reg;
  logic slot_end;
  logic wave_next;

  // A slot is 32 source periods; each ramp level lasts (Q+1)*32 periods
  assign slot_end = src_tick_i && (sub_reg == 5'h1F);

  // ********************************************************
  // Phase sequencing
  // ********************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !run_i) begin
      sub_reg <= 5'h00;
      level_reg <= 5'h00;
      rep_reg <= 7'h00;
      hold_reg <= 8'h00;
      phase_reg <= PMX_RISE;
    end else begin
      if (src_tick_i) begin
        sub_reg <= sub_reg + 5'h01;
      end
      if (slot_end) begin
        case (phase_reg)
          PMX_RISE, PMX_FALL: begin
            // Each ramp: 32 levels of (Q+1) slots of 32t cover (Q+1)*32*32t
            if (rep_reg == {5'h00, ramp_i}) begin
              rep_reg <= 7'h00;
              if (level_reg == 5'h1F) begin
                level_reg <= 5'h00;
                hold_reg <= 8'h00;
                phase_reg <= (phase_reg == PMX_RISE) ? PMX_HOLD_HI : PMX_HOLD_LO;
              end else begin
                level_reg <= level_reg + 5'h01;
              end
            end else begin
              rep_reg <= rep_reg + 7'h01;
            end
          end
          PMX_HOLD_HI: begin
            if (hold_reg + 8'h01 >= high_i || high_i == 8'h00) begin
              phase_reg <= PMX_FALL;
            end else begin
              hold_reg <= hold_reg + 8'h01;
            end
          end
          PMX_HOLD_LO: begin
            if (hold_reg + 8'h01 >= low_i || low_i == 8'h00) begin
              phase_reg <= PMX_RISE;
            end else begin
              hold_reg <= hold_reg + 8'h01;
            end
          end
          default: begin
            phase_reg <= PMX_RISE;
          end
        endcase
      end
    end
  end

  // Duty within a 32-period slot follows the ramp level
  always_comb begin
    case (phase_reg)
      PMX_RISE: wave_next = (sub_reg < level_reg);
      PMX_FALL: wave_next = (sub_reg < (5'h1F - level_reg)) || (level_reg == 5'h00);
      PMX_HOLD_HI: wave_next = 1'b1;
      default: wave_next = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wave_o <= 1'b0;
    end else begin
      wave_o <= run_i && wave_next;
    end
  end

  assign phase_o = phase_reg;
endmodule
`default_nettype wire

// *** pmx_top.sv ***
// Pad mux, pull, hysteresis, drive and pulse-width configuration block.
// Assumes a strobe register port and a source-clock tick from the clock unit.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module pmx_top #(
  parameter int DUTY_W = 8 // Normal duty field width
) (
  input wire logic ref_clk_i, // 40 MHz clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rdata_o, // Read data, cycle after strobe
  input wire logic src_tick_i, // Pulse-source clock tick
  input wire logic [14:0] gpio_en_i, // General-purpose function active per pad
  input wire logic [14:0] gpio_out_i, // General-purpose output level per pad
  input wire logic uart_tx_i, // UART transmit from peripheral
  input wire logic uart_rts_i, // UART request-to-send from peripheral
  output logic pwm_o, // Pulse-width output
  output logic [14:0] pad_out_o, // Pad output level
  output logic [14:0] pad_oe_o, // Pad output enable, high drives
  output logic [14:0] pad_analog_o, // Pad handed to analog function
  output logic serial_in_on_pad7_o, // Serial receive data taken from pad seven
  output logic uart_rx_on_pad14_o, // UART receive taken from pad fourteen
  output logic usb_plus_line_en_o, // Pad twelve given to USB plus line
  output logic temperature_converter_en_o, // Pad three to temperature converter
  output logic low_rate_converter_two_en_o, // Pad four to low-rate converter two
  output logic low_rate_converter_one_en_o, // Pad eight to low-rate converter one
  output logic [7:0] fixed_pull_o, // Effective fixed pull enables
  output logic [18:0] input_hysteresis_o, // Hysteresis enables
  output logic [29:0] pad_drive_o // Drive codes, pads nine to zero
);
  import pmx_pkg::*;

  // ********************************************************
  // Register file
  // ********************************************************
  logic [31:0] pwm_output_control_reg;
  logic [31:0] pad_function_routing_reg;
  logic [31:0] analog_digital_pin_select_reg;
  logic [31:0] fixed_pull_enable_reg;
  logic [31:0] pad_hysteresis_control_reg;
  logic [31:0] pad_drive_strength_low_reg;
  logic [31:0] rdata_next;
  logic breath_wave;
  pmx_phase_type breath_phase;

  // Reserved bits are masked on write so they always read zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pwm_output_control_reg <= PMX_ZERO_RST;
    end else if (wr_i && addr_i == PMX_PWM_OUTPUT_CONTROL_OFS) begin
      pwm_output_control_reg <= wdata_i & PMX_PWM_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pad_function_routing_reg <= PMX_ZERO_RST;
    end else if (wr_i && addr_i == PMX_ROUTE_OFS) begin
      pad_function_routing_reg <= wdata_i & PMX_ROUTE_MASK;
    end
  end

  // Bit 7 is stored as written; setting it is the software's fault
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      analog_digital_pin_select_reg <= PMX_ZERO_RST;
    end else if (wr_i && addr_i == PMX_ADSEL_OFS) begin
      analog_digital_pin_select_reg <= wdata_i & PMX_ADSEL_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fixed_pull_enable_reg <= PMX_ZERO_RST;
    end else if (wr_i && addr_i == PMX_PULL_OFS) begin
      fixed_pull_enable_reg <= wdata_i & PMX_PULL_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pad_hysteresis_control_reg <= PMX_ZERO_RST;
    end else if (wr_i && addr_i == PMX_HYST_OFS) begin
      pad_hysteresis_control_reg <= wdata_i & PMX_HYST_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pad_drive_strength_low_reg <= PMX_DRV_RST;
    end else if (wr_i && addr_i == PMX_DRV_OFS) begin
      pad_drive_strength_low_reg <= wdata_i & PMX_DRV_MASK;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (addr_i)
      PMX_PWM_OUTPUT_CONTROL_OFS: rdata_next = pwm_output_control_reg;
      PMX_ROUTE_OFS: rdata_next = pad_function_routing_reg;
      PMX_ADSEL_OFS: rdata_next = analog_digital_pin_select_reg;
      PMX_PULL_OFS: rdata_next = fixed_pull_enable_reg;
      PMX_HYST_OFS: rdata_next = pad_hysteresis_control_reg;
      PMX_DRV_OFS: rdata_next = pad_drive_strength_low_reg;
      PMX_STAT_OFS: rdata_next = {29'h0000_0000, breath_phase, pwm_o};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // ********************************************************
  // Pulse-width generation
  // ********************************************************
  logic breath_mode;
  logic [DUTY_W-1:0] norm_cnt_reg;
  logic norm_active;
  logic pwm_next;

  assign breath_mode = pwm_output_control_reg[PMX_MODE_BIT];

  // 256-period frame; active for duty+1 periods of it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || breath_mode) begin
      norm_cnt_reg <= '0;
    end else if (src_tick_i) begin
      norm_cnt_reg <= norm_cnt_reg + 1'b1;
    end
  end

  assign norm_active = (norm_cnt_reg <= pwm_output_control_reg[DUTY_W-1:0]);

  pmx_breath u_breath (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(breath_mode),
    .src_tick_i(src_tick_i),
    .ramp_i(pwm_output_control_reg[PMX_RAMP_LSB +: 2]),
    .high_i(pwm_output_control_reg[PMX_HIGH_LSB +: 8]),
    .low_i(pwm_output_control_reg[PMX_LOW_LSB +: 8]),
    .wave_o(breath_wave),
    .phase_o(breath_phase)
  );

  // Polarity only matters in normal mode; inactive level is its inverse
  always_comb begin
    if (breath_mode) begin
      pwm_next = breath_wave;
    end else if (pwm_output_control_reg[PMX_POL_BIT]) begin
      pwm_next = norm_active;
    end else begin
      pwm_next = !norm_active;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pwm_o <= 1'b0;
    end else begin
      pwm_o <= pwm_next;
    end
  end

  // ********************************************************
  // Pad function selection
  // ********************************************************
  logic [14:0] analog_sel;
  logic [14:0] periph_oe;
  logic [14:0] periph_out;

  // Analog selections per pad
  always_comb begin
    analog_sel = 15'h0000;
    analog_sel[3] = analog_digital_pin_select_reg[2];
    analog_sel[4] = analog_digital_pin_select_reg[1];
    analog_sel[8] = analog_digital_pin_select_reg[0];
  end

  // Peripheral routing drives for the upper pads
  always_comb begin
    periph_oe = 15'h0000;
    periph_out = 15'h0000;
    periph_oe[13] = pad_function_routing_reg[PMX_P13_BIT];
    periph_out[13] = uart_tx_i;
    periph_oe[12] = pad_function_routing_reg[PMX_P12_BIT];
    periph_out[12] = uart_rts_i;
  end

  // Analog first, then general-purpose, then peripheral routing
  genvar p;
  generate
    for (p = 0; p < 15; p++) begin : g_pad
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          pad_out_o[p] <= 1'b0;
          pad_oe_o[p] <= 1'b0;
          pad_analog_o[p] <= 1'b0;
        end else if (analog_sel[p]) begin
          pad_out_o[p] <= 1'b0;
          pad_oe_o[p] <= 1'b0;
          pad_analog_o[p] <= 1'b1;
        end else if (gpio_en_i[p]) begin
          pad_out_o[p] <= gpio_out_i[p];
          pad_oe_o[p] <= 1'b1;
          pad_analog_o[p] <= 1'b0;
        end else begin
          pad_out_o[p] <= periph_out[p];
          pad_oe_o[p] <= periph_oe[p];
          pad_analog_o[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // Routing status, registered for clean pad-side timing
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      serial_in_on_pad7_o <= 1'b0;
      uart_rx_on_pad14_o <= 1'b0;
      usb_plus_line_en_o <= 1'b0;
      temperature_converter_en_o <= 1'b0;
      low_rate_converter_two_en_o <= 1'b0;
      low_rate_converter_one_en_o <= 1'b0;
    end else begin
      serial_in_on_pad7_o <= pad_function_routing_reg[PMX_SIN_BIT] && !analog_sel[7] && !gpio_en_i[7];
      uart_rx_on_pad14_o <= pad_function_routing_reg[PMX_P14_BIT] && !gpio_en_i[14];
      usb_plus_line_en_o <= !pad_function_routing_reg[PMX_P12_BIT] && !gpio_en_i[12];
      temperature_converter_en_o <= analog_sel[3];
      low_rate_converter_two_en_o <= analog_sel[4];
      low_rate_converter_one_en_o <= analog_sel[8];
    end
  end

  // ********************************************************
  // Pulls, hysteresis and drive
  // ********************************************************
  // UART receive pull-up also comes on when pad fourteen is routed to it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fixed_pull_o <= 8'h00;
    end else begin
      fixed_pull_o <= fixed_pull_enable_reg[7:0];
      if (pad_function_routing_reg[PMX_P14_BIT] && !gpio_en_i[14]) begin
        fixed_pull_o[6] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      input_hysteresis_o <= 19'h00000;
      pad_drive_o <= PMX_DRV_RST[29:0];
    end else begin
      input_hysteresis_o <= pad_hysteresis_control_reg[18:0];
      pad_drive_o <= pad_drive_strength_low_reg[PMX_DRV_PADS*PMX_DRV_W-1:0];
    end
  end
endmodule
`default_nettype wire

// *** pmx_top_sva.sv ***
// Checker for the pad mux block, bound to its top module.
// Assumes register effects reach the outputs two edges after the write strobe.
`timescale 1ns/10ps
`default_nettype none
module pmx_top_sva #(
  parameter int DUTY_W = 8 // Normal duty field width
) (
  input wire logic ref_clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic [7:0] addr_i, // Register address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic [14:0] gpio_en_i, // General-purpose owner
  input wire logic [14:0] pad_oe_o, // Pad enables
  input wire logic [14:0] pad_analog_o, // Analog pads
  input wire logic serial_in_on_pad7_o, // Serial input moved
  input wire logic uart_rx_on_pad14_o, // UART receive routed
  input wire logic temperature_converter_en_o, // Pad three analog
  input wire logic low_rate_converter_two_en_o, // Pad four analog
  input wire logic low_rate_converter_one_en_o, // Pad eight analog
  input wire logic [7:0] fixed_pull_o, // Pull enables
  input wire logic [18:0] input_hysteresis_o, // Hysteresis enables
  input wire logic [29:0] pad_drive_o // Drive codes
);
  import pmx_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Reset itself is the cause here, so it must not disable the check
  chk_drive_reset_val: assert property (disable iff (1'b0)
    rst_i ##1 rst_i |=> pad_drive_o == PMX_DRV_RST[29:0]) else $error("drive codes not at reset value");
  chk_drive_write_copy: assert property (wr_i && addr_i == PMX_DRV_OFS |-> ##2
    pad_drive_o == $past(wdata_i[29:0], 2)) else $error("drive codes differ from write");
  chk_hyst_write_copy: assert property (wr_i && addr_i == PMX_HYST_OFS |=> ##1
    input_hysteresis_o == $past(wdata_i[18:0], 2)) else $error("hysteresis differs from write");
  // A general-purpose owner of pad seven outranks the routing bit
  chk_serial_route: assert property (wr_i && addr_i == PMX_ROUTE_OFS |=> ##1
    serial_in_on_pad7_o == ($past(wdata_i[PMX_SIN_BIT], 2) && !$past(gpio_en_i[7])))
    else $error("serial input route wrong");
  chk_analog_select: assert property (wr_i && addr_i == PMX_ADSEL_OFS |-> ##2
    {temperature_converter_en_o, low_rate_converter_two_en_o, low_rate_converter_one_en_o}
    == $past(wdata_i[2:0], 2)) else $error("analog selects differ from write");
  chk_analog_first: assert property ((pad_analog_o & pad_oe_o) == 15'h0000)
    else $error("analog pad also driven");
  chk_auto_pull_up: assert property ((uart_rx_on_pad14_o && !gpio_en_i[14]) [*3] |->
    fixed_pull_o[6]) else $error("routed receive pull not enabled");
  chk_pull_write_copy: assert property (wr_i && addr_i == PMX_PULL_OFS |-> ##2
    {fixed_pull_o[7], fixed_pull_o[5:0]} == {$past(wdata_i[7], 2), $past(wdata_i[5:0], 2)})
    else $error("pull enables differ from write");
  cov_breathing: cover property (wr_i && addr_i == PMX_PWM_OUTPUT_CONTROL_OFS && wdata_i[PMX_MODE_BIT]);
  cov_auto_pull: cover property (fixed_pull_o[6] && uart_rx_on_pad14_o);
  cov_unmapped: cover property (wr_i && addr_i == 8'h44);
endmodule
bind pmx_top pmx_top_sva #(.DUTY_W(DUTY_W)) i_sva (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .gpio_en_i(gpio_en_i), .pad_oe_o(pad_oe_o), .pad_analog_o(pad_analog_o),
  .serial_in_on_pad7_o(serial_in_on_pad7_o), .uart_rx_on_pad14_o(uart_rx_on_pad14_o),
  .temperature_converter_en_o(temperature_converter_en_o),
  .low_rate_converter_two_en_o(low_rate_converter_two_en_o),
  .low_rate_converter_one_en_o(low_rate_converter_one_en_o), .fixed_pull_o(fixed_pull_o),
  .input_hysteresis_o(input_hysteresis_o), .pad_drive_o(pad_drive_o)
);
`default_nettype wire

// *** pmx_pads_model.sv ***
// Far side model: clock-unit pulse source tick and UART peripheral levels.
// Assumes one free-running system clock; the tick source runs free.
`timescale 1ns/10ps
`default_nettype none
module pmx_pads_model (
  input wire logic ref_clk_i, // Clock
  input wire logic slow_i, // Tick every fourth cycle
  output logic src_tick_o, // Pulse-source tick
  output logic uart_tx_o, // UART transmit level
  output logic uart_rts_o // UART request-to-send level
);
  logic [1:0] div_reg = 2'h0;
  logic tx_reg = 1'b1;
  logic rts_reg = 1'b0;
  // Peripheral levels wander so a stuck pad output shows up
  always_ff @(posedge ref_clk_i) begin
    div_reg <= div_reg + 2'h1;
    tx_reg <= 1'($urandom());
    rts_reg <= 1'($urandom());
  end
  // Slow mode stretches every count fourfold
  assign src_tick_o = slow_i ? (div_reg == 2'h0) : 1'b1;
  assign uart_tx_o = tx_reg;
  assign uart_rts_o = rts_reg;
endmodule
`default_nettype wire

// *** pmx_top_tb.sv ***
// Self-checking bench for the pad mux and pulse-width block.
// Assumes the checker is bound in and the far side model is compiled first.
`timescale 1ns/10ps
`default_nettype none
module pmx_top_tb;
  import pmx_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic slow = 1'b0;
  logic [14:0] gpio_en_i = 15'h0000;
  logic [14:0] gpio_out_i = 15'h0000;
  logic src_tick, uart_tx, uart_rts, pwm, sin7, rx14, usb_en, t_en, l2_en, l1_en;
  logic [31:0] rdata;
  logic [14:0] pad_out, pad_oe, pad_an;
  logic [7:0] pull;
  logic [18:0] hyst;
  logic [29:0] drv;
  int miscompares = 0;
  int tests_run = 0;
  localparam logic [7:0] OFS [6] = '{PMX_PWM_OUTPUT_CONTROL_OFS, PMX_ROUTE_OFS, PMX_ADSEL_OFS, PMX_PULL_OFS,
    PMX_HYST_OFS, PMX_DRV_OFS};
  localparam logic [31:0] MSK [6] = '{PMX_PWM_MASK, PMX_ROUTE_MASK, PMX_ADSEL_MASK, PMX_PULL_MASK,
    PMX_HYST_MASK, PMX_DRV_MASK};
  localparam logic [31:0] RST [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, PMX_DRV_RST};
  // ****************************************
  // Design and far side
  // ****************************************
  pmx_pads_model i_pads (.ref_clk_i(ref_clk_i), .slow_i(slow), .src_tick_o(src_tick),
    .uart_tx_o(uart_tx), .uart_rts_o(uart_rts));
  pmx_top #(.DUTY_W(8)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .src_tick_i(src_tick),
    .gpio_en_i(gpio_en_i), .gpio_out_i(gpio_out_i), .uart_tx_i(uart_tx), .uart_rts_i(uart_rts),
    .pwm_o(pwm), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_analog_o(pad_an),
    .serial_in_on_pad7_o(sin7), .uart_rx_on_pad14_o(rx14), .usb_plus_line_en_o(usb_en),
    .temperature_converter_en_o(t_en), .low_rate_converter_two_en_o(l2_en),
    .low_rate_converter_one_en_o(l1_en), .fixed_pull_o(pull), .input_hysteresis_o(hyst),
    .pad_drive_o(drv));
  // ****************************************
  // Helpers
  // ****************************************
  always #12.5 ref_clk_i = ~ref_clk_i;
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    check(name, exp, rdata);
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  function automatic int exp_high(input logic [7:0] duty, input logic pol, input int div);
    return pol ? (duty + 1) * div : (255 - duty) * div;
  endfunction
  // Breathing set up with ramp 1, high hold 2, low hold 3
  function automatic int exp_len(input logic [1:0] ph);
    case (ph)
      PMX_HOLD_HI: return 2 * PMX_TICK_UNIT;
      PMX_HOLD_LO: return 3 * PMX_TICK_UNIT;
      default: return 2 * PMX_RAMP_STEPS * PMX_TICK_UNIT;
    endcase
  endfunction
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog sized well above the expected run of about 11500 cycles
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    miscompares++;
    complete_run();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [7:0] duty;
    logic [1:0] ph;
    logic [31:0] hi; // Four-state so an unknown output level is not counted as low
    int k, cnt, segs, pidx;
    void'($urandom(56));
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(OFS[i], RST[i], "reset value");
    check("drive out", PMX_DRV_RST & PMX_DRV_MASK, {2'b00, drv});
    // Random traffic, reserved bits must read back as zero
    for (int n = 0; n < 30; n++) begin
      k = n % 6;
      d = $urandom();
      if (k == 2) d[7] = 1'b0;
      gpio_en_i <= 15'($urandom());
      gpio_out_i <= 15'($urandom());
      wr(OFS[k], d);
      rd(OFS[k], d & MSK[k], "readback");
      if (k == 5) check("drive out", {2'b00, d[29:0]}, {2'b00, drv});
      if (k == 4) check("hyst out", {13'h0, d[18:0]}, {13'h0, hyst});
    end
    wr(8'h44, 32'hFFFF_FFFF);
    rd(8'h44, 32'h0000_0000, "unmapped");
    // Analog beats general-purpose on every selectable pad
    gpio_en_i <= 15'h7FFF;
    wr(PMX_ROUTE_OFS, 32'h0000_0000);
    for (int b = 0; b < 3; b++) begin
      pidx = (b == 2) ? 3 : (b == 1) ? 4 : 8;
      wr(PMX_ADSEL_OFS, 32'h1 << b);
      settle();
      check("analog en", 32'h1 << b, {29'h0, t_en, l2_en, l1_en});
      check("analog pad", 32'h1 << pidx, {17'h0, pad_an});
      check("pad oe", 32'h7FFF & ~(32'h1 << pidx), {17'h0, pad_oe});
      check("pad out", {17'h0, gpio_out_i & ~(15'h1 << pidx)}, {17'h0, pad_out});
    end
    wr(PMX_ADSEL_OFS, 32'h0000_0000);
    gpio_en_i <= 15'h0000;
    for (int v = 0; v < 2; v++) begin
      wr(PMX_ROUTE_OFS, v ? 32'h002E_0000 : 32'h0000_0000);
      settle();
      check("routes", v ? 32'h6 : 32'h1, {29'h0, sin7, rx14, usb_en});
    end
    // Peripheral drives pads 13 and 12 one edge after its levels
    @(negedge ref_clk_i);
    d = {30'h0, uart_tx, uart_rts};
    @(posedge ref_clk_i);
    #1;
    check("uart pads", {28'h0, 2'b11, d[1:0]}, {28'h0, pad_oe[13:12], pad_out[13:12]});
    // Receive routed with no general-purpose owner turns its pull on
    wr(PMX_PULL_OFS, 32'h0000_00BF);
    settle();
    check("auto pull", 32'hFF, {24'h0, pull});
    rd(PMX_PULL_OFS, 32'h0000_00BF, "pull reg");
    gpio_en_i[14] <= 1'b1;
    settle();
    check("pull", 32'hBF, {24'h0, pull});
    // Normal mode duty and polarity, one case at the slow tick rate
    for (int n = 0; n < 6; n++) begin
      duty = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : 8'($urandom());
      slow <= (n == 5);
      wr(PMX_PWM_OUTPUT_CONTROL_OFS, {4'h0, 1'(n % 2), 19'h0, duty});
      repeat (8) @(posedge ref_clk_i);
      hi = 0;
      repeat ((n == 5) ? 1024 : 256) begin
        @(posedge ref_clk_i);
        #1;
        hi += pwm;
      end
      check("duty high", exp_high(duty, 1'(n % 2), (n == 5) ? 4 : 1), hi);
    end
    // Breathing phases timed through back-to-back status reads
    slow <= 1'b0;
    wr(PMX_PWM_OUTPUT_CONTROL_OFS, 32'h0502_0300);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= PMX_STAT_OFS;
    ph = PMX_RISE;
    cnt = 0;
    segs = 0;
    repeat (9000) begin
      @(posedge ref_clk_i);
      #1;
      cnt++;
      if (rdata[2:1] !== ph) begin
        if (segs > 0) check("phase length", exp_len(ph), cnt);
        check("phase order", {30'h0, 2'(ph + 2'h1)}, {30'h0, rdata[2:1]});
        segs++;
        ph = rdata[2:1];
        cnt = 0;
      end
    end
    rd_i <= 1'b0;
    check("phase changes", 32'h1, {31'h0, segs >= 6});
    complete_run();
  end
endmodule
`default_nettype wire
